// file: charger_event_status_regs.v
`timescale 1ns/100ps
`include "charger_regs.vh"
//==========================================================================
// event, status, command and mask registers behind a serial slave port
//==========================================================================
module charger_event_status_regs #(
  parameter [6:0] DEV_ADDR = `DEV_ADDR_DEFAULT
) (
  input  wire I_CLK,
  input  wire I_RST_B,
  // serial link pins
  input  wire I_SCL,
  input  wire I_SDA,
  output wire O_SDA_OUT,
  output wire O_SDA_OE,
  // analog and supervisor condition levels
  input  wire I_MAIN_CURRENT_REGULATING,
  input  wire I_EXT_CLOCK_RANGE_FAULT,
  input  wire I_FREQ_RESISTOR_RANGE_FAULT,
  input  wire I_HARD_THERMAL_TRIP,
  input  wire I_SOFT_THERMAL_TRIP,
  input  wire I_INPUT_OVERVOLTAGE_LOCKOUT,
  input  wire I_MAIN_OVERCURRENT,
  input  wire I_MAIN_OVERVOLTAGE_FLAG,
  input  wire I_MAIN_UNDERVOLTAGE_FLAG,
  input  wire I_AUX_REGULATOR_UNDERVOLTAGE,
  input  wire I_BIAS_CONV_OVERCURRENT,
  input  wire I_BIAS_CONV_OVERVOLTAGE,
  input  wire I_BIAS_CONV_UNDERVOLTAGE,
  input  wire I_EXT_CLOCK_TOO_FAST,
  input  wire I_EXT_CLOCK_TOO_SLOW,
  input  wire I_BIAS_FULL_DUTY,
  input  wire I_MAIN_FULL_DUTY,
  input  wire I_MAIN_OUTPUT_GOOD,
  // device actions and interrupt
  output wire O_APPLY_VOLTAGE_SETPOINT,
  output wire O_MAIN_ENABLE,
  output wire O_INT_B
);

  //========================================================================
  // serial slave states
  //========================================================================
  localparam [2:0] ST_IDLE  = 3'd0;
  localparam [2:0] ST_ADDR  = 3'd1;
  localparam [2:0] ST_ACK_A = 3'd2;
  localparam [2:0] ST_WDATA = 3'd3;
  localparam [2:0] ST_ACK_W = 3'd4;
  localparam [2:0] ST_RDATA = 3'd5;
  localparam [2:0] ST_ACK_R = 3'd6;

  //========================================================================
  // declarations
  //========================================================================
  wire [19:0] raw_in;
  wire [19:0] sync_in;
  wire        scl_f;
  wire        sda_f;
  wire        ccm_f;
  reg         scl_p_reg;
  reg         sda_p_reg;
  reg         ccm_p_reg;
  wire        scl_rise;
  wire        scl_fall;
  wire        start_seen;
  wire        stop_seen;
  wire        mode_change;

  reg  [2:0]  state_reg;
  reg  [3:0]  bit_cnt_reg;
  reg  [7:0]  shift_reg;
  reg  [7:0]  tx_reg;
  reg  [7:0]  ptr_reg;
  reg         rw_reg;
  reg         first_reg;
  reg         sda_oe_reg;
  reg         sda_out_reg;

  reg  [7:0]  action_reg;
  reg  [7:0]  gate_a_reg;
  reg  [7:0]  gate_b_reg;
  reg  [7:0]  cfg1_reg;
  reg         apply_reg;
  reg         enable_reg;
  reg         int_b_reg;
  reg         clr_a_reg;
  reg         clr_b_reg;

  reg  [7:0]  cause_a;
  reg  [7:0]  cause_b;
  reg  [7:0]  live_flags;
  reg  [7:0]  rd_byte;
  wire [7:0]  flags_a;
  wire [7:0]  flags_b;
  wire        load_byte;
  wire        write_byte;
  wire        pending;

  //========================================================================
  // helpers
  //========================================================================
  // effective mask after the mask-all override
  function [7:0] eff_mask;
    input [7:0] gate;
    input       mask_all;
    begin
      eff_mask = gate | {8{mask_all}};
    end
  endfunction

  //========================================================================
  // input synchronisation
  //========================================================================
  // pins and analog levels all come from outside the clock domain
  assign raw_in = {I_SCL, I_SDA, I_MAIN_CURRENT_REGULATING, I_EXT_CLOCK_RANGE_FAULT,
                   I_FREQ_RESISTOR_RANGE_FAULT, I_HARD_THERMAL_TRIP, I_SOFT_THERMAL_TRIP,
                   I_INPUT_OVERVOLTAGE_LOCKOUT, I_MAIN_OVERCURRENT, I_MAIN_OVERVOLTAGE_FLAG,
                   I_MAIN_UNDERVOLTAGE_FLAG, I_AUX_REGULATOR_UNDERVOLTAGE,
                   I_BIAS_CONV_OVERCURRENT, I_BIAS_CONV_OVERVOLTAGE,
                   I_BIAS_CONV_UNDERVOLTAGE, I_EXT_CLOCK_TOO_FAST, I_EXT_CLOCK_TOO_SLOW,
                   I_BIAS_FULL_DUTY, I_MAIN_FULL_DUTY, I_MAIN_OUTPUT_GOOD};

  in_sync #(
    .W    (2),
    .INIT (1'b1)
  ) u_link_sync (
    .i_clk   (I_CLK),
    .i_rst_b (I_RST_B),
    .i_async (raw_in[19:18]),
    .o_level (sync_in[19:18])
  );

  in_sync #(
    .W    (18),
    .INIT (1'b0)
  ) u_cond_sync (
    .i_clk   (I_CLK),
    .i_rst_b (I_RST_B),
    .i_async (raw_in[17:0]),
    .o_level (sync_in[17:0])
  );

  assign scl_f = sync_in[19];
  assign sda_f = sync_in[18];
  assign ccm_f = sync_in[17];

  // previous filtered values for edge finding
  always @(posedge I_CLK) begin
    if (!I_RST_B) begin
      scl_p_reg <= 1'b1;
      sda_p_reg <= 1'b1;
      ccm_p_reg <= 1'b0;
    end else begin
      scl_p_reg <= scl_f;
      sda_p_reg <= sda_f;
      ccm_p_reg <= ccm_f;
    end
  end

  // link edges and frame markers
  assign scl_rise    = scl_f & ~scl_p_reg;
  assign scl_fall    = ~scl_f & scl_p_reg;
  assign start_seen  = scl_f & scl_p_reg & sda_p_reg & ~sda_f;
  assign stop_seen   = scl_f & scl_p_reg & ~sda_p_reg & sda_f;
  assign mode_change = ccm_f ^ ccm_p_reg;

  //========================================================================
  // event causes and live status
  //========================================================================
  // map conditions onto flag positions
  always @* begin
    cause_a                  = 8'h00;
    cause_a[`FA_MODE_CHANGE] = mode_change;
    cause_a[`FA_EXT_CLOCK]   = sync_in[16];
    cause_a[`FA_FREQ_RES]    = sync_in[15];
    cause_a[`FA_HARD_TRIP]   = sync_in[14];
    cause_a[`FA_SOFT_TRIP]   = sync_in[13];
    cause_a[`FA_INPUT_OVLO]  = sync_in[12];
    cause_b                  = 8'h00;
    cause_b[`FB_MAIN_OC]     = sync_in[11];
    cause_b[`FB_MAIN_OV]     = sync_in[10];
    cause_b[`FB_MAIN_UV]     = sync_in[9];
    cause_b[`FB_AUX_UV]      = sync_in[8];
    cause_b[`FB_BIAS_OC]     = sync_in[7];
    cause_b[`FB_BIAS_OV]     = sync_in[6];
    cause_b[`FB_BIAS_UV]     = sync_in[5];
  end

  // live condition byte, no interrupt path
  always @* begin
    live_flags                  = 8'h00;
    live_flags[`ST_TOO_FAST]    = sync_in[4];
    live_flags[`ST_TOO_SLOW]    = sync_in[3];
    live_flags[`ST_BIAS_FULL]   = sync_in[2];
    live_flags[`ST_CURRENT_REG] = ccm_f;
    live_flags[`ST_MAIN_FULL]   = sync_in[1];
    live_flags[`ST_MAIN_GOOD]   = sync_in[0];
  end

  event_latch_bank #(
    .USED (`USED_FLAGS_A)
  ) u_flags_a (
    .i_clk      (I_CLK),
    .i_rst_b    (I_RST_B),
    .i_cause    (cause_a),
    .i_read_clr (clr_a_reg),
    .o_flags    (flags_a)
  );

  event_latch_bank #(
    .USED (`USED_FLAGS_B)
  ) u_flags_b (
    .i_clk      (I_CLK),
    .i_rst_b    (I_RST_B),
    .i_cause    (cause_b),
    .i_read_clr (clr_b_reg),
    .o_flags    (flags_b)
  );

  //========================================================================
  // register read mux
  //========================================================================
  // byte served for the current pointer
  always @* begin
    case (ptr_reg)
      `OFS_FLAGS_A: begin
        rd_byte = flags_a;
      end
      `OFS_FLAGS_B: begin
        rd_byte = flags_b;
      end
      `OFS_LIVE: begin
        rd_byte = live_flags;
      end
      `OFS_ACTION: begin
        rd_byte = action_reg & ~(8'h01 << `ACT_APPLY);
      end
      `OFS_GATE_A: begin
        rd_byte = gate_a_reg;
      end
      `OFS_GATE_B: begin
        rd_byte = gate_b_reg;
      end
      `OFS_CFG1: begin
        rd_byte = cfg1_reg;
      end
      default: begin
        rd_byte = 8'h00; // state, spare and unmapped bytes
      end
    endcase
  end

  // a byte is fetched after the address ack or a host ack on reads
  assign load_byte  = scl_fall & ((state_reg == ST_ACK_A & rw_reg) |
                                  (state_reg == ST_ACK_R & ~shift_reg[0]));
  assign write_byte = scl_fall & (state_reg == ST_WDATA) & (bit_cnt_reg == 4'd8) & ~first_reg;

  //========================================================================
  // serial slave sequencer
  //========================================================================
  // bits are taken on clock rise and driven after clock fall
  always @(posedge I_CLK) begin
    if (!I_RST_B) begin
      state_reg   <= ST_IDLE;
      bit_cnt_reg <= 4'd0;
      shift_reg   <= 8'h00;
      tx_reg      <= 8'h00;
      ptr_reg     <= 8'h00;
      rw_reg      <= 1'b0;
      first_reg   <= 1'b0;
      sda_oe_reg  <= 1'b0;
      sda_out_reg <= 1'b0;
    end else if (start_seen) begin
      state_reg   <= ST_ADDR;
      bit_cnt_reg <= 4'd0;
      sda_oe_reg  <= 1'b0;
    end else if (stop_seen) begin
      state_reg   <= ST_IDLE;
      sda_oe_reg  <= 1'b0;
    end else begin
      case (state_reg)
        ST_ADDR: begin
          if (scl_rise) begin
            shift_reg   <= {shift_reg[6:0], sda_f};
            bit_cnt_reg <= bit_cnt_reg + 4'd1;
          end else if (scl_fall && bit_cnt_reg == 4'd8) begin
            if (shift_reg[7:1] == DEV_ADDR) begin
              rw_reg     <= shift_reg[0];
              sda_oe_reg <= 1'b1;
              state_reg  <= ST_ACK_A;
            end else begin
              state_reg  <= ST_IDLE;
            end
          end
        end
        ST_ACK_A: begin
          if (scl_fall) begin
            bit_cnt_reg <= 4'd0;
            if (rw_reg) begin
              tx_reg     <= rd_byte;
              sda_oe_reg <= ~rd_byte[7];
              ptr_reg    <= ptr_reg + 8'd1;
              state_reg  <= ST_RDATA;
            end else begin
              sda_oe_reg <= 1'b0;
              first_reg  <= 1'b1;
              state_reg  <= ST_WDATA;
            end
          end
        end
        ST_WDATA: begin
          if (scl_rise) begin
            shift_reg   <= {shift_reg[6:0], sda_f};
            bit_cnt_reg <= bit_cnt_reg + 4'd1;
          end else if (scl_fall && bit_cnt_reg == 4'd8) begin
            sda_oe_reg <= 1'b1;
            first_reg  <= 1'b0;
            state_reg  <= ST_ACK_W;
            if (first_reg) begin
              ptr_reg <= shift_reg;
            end else begin
              ptr_reg <= ptr_reg + 8'd1;
            end
          end
        end
        ST_ACK_W: begin
          if (scl_fall) begin
            sda_oe_reg  <= 1'b0;
            bit_cnt_reg <= 4'd0;
            state_reg   <= ST_WDATA;
          end
        end
        ST_RDATA: begin
          if (scl_rise) begin
            bit_cnt_reg <= bit_cnt_reg + 4'd1;
          end else if (scl_fall) begin
            if (bit_cnt_reg == 4'd8) begin
              sda_oe_reg <= 1'b0;
              state_reg  <= ST_ACK_R;
            end else begin
              tx_reg     <= {tx_reg[6:0], 1'b0};
              sda_oe_reg <= ~tx_reg[6];
            end
          end
        end
        ST_ACK_R: begin
          if (scl_rise) begin
            shift_reg <= {7'h00, sda_f}; // host ack level
          end else if (scl_fall) begin
            bit_cnt_reg <= 4'd0;
            if (!shift_reg[0]) begin
              tx_reg     <= rd_byte;
              sda_oe_reg <= ~rd_byte[7];
              ptr_reg    <= ptr_reg + 8'd1;
              state_reg  <= ST_RDATA;
            end else begin
              state_reg  <= ST_IDLE;
            end
          end
        end
        default: begin
          sda_oe_reg <= 1'b0;
          state_reg  <= ST_IDLE;
        end
      endcase
    end
  end

  //========================================================================
  // writable registers and command pulses
  //========================================================================
  // register writes land on the data byte's eighth falling edge
  always @(posedge I_CLK) begin
    if (!I_RST_B) begin
      action_reg <= `RST_ACTION;
      gate_a_reg <= `RST_GATE;
      gate_b_reg <= `RST_GATE;
      cfg1_reg   <= `RST_CFG1;
      apply_reg  <= 1'b0;
      enable_reg <= 1'b0;
    end else begin
      apply_reg  <= 1'b0;
      enable_reg <= 1'b0;
      if (write_byte) begin
        case (ptr_reg)
          `OFS_ACTION: begin
            action_reg <= shift_reg & (8'h01 << `ACT_ENABLE);
            apply_reg  <= shift_reg[`ACT_APPLY];
            enable_reg <= shift_reg[`ACT_ENABLE];
          end
          `OFS_GATE_A: begin
            gate_a_reg <= shift_reg & `USED_FLAGS_A;
          end
          `OFS_GATE_B: begin
            gate_b_reg <= shift_reg & `USED_FLAGS_B;
          end
          `OFS_CFG1: begin
            cfg1_reg <= shift_reg & `USED_CFG1;
          end
          default: begin
            cfg1_reg <= cfg1_reg; // read-only and unmapped bytes ignore writes
          end
        endcase
      end
    end
  end

  //========================================================================
  // read clear strobes and interrupt
  //========================================================================
  // unmasked pending flags
  assign pending = |(flags_a & ~eff_mask(gate_a_reg, cfg1_reg[`CFG1_MASK_ALL])) |
                   |(flags_b & ~eff_mask(gate_b_reg, cfg1_reg[`CFG1_MASK_ALL]));

  // clear strobe follows the fetch of a flag byte
  always @(posedge I_CLK) begin
    if (!I_RST_B) begin
      clr_a_reg <= 1'b0;
      clr_b_reg <= 1'b0;
      int_b_reg <= 1'b1;
    end else begin
      clr_a_reg <= load_byte & (ptr_reg == `OFS_FLAGS_A);
      clr_b_reg <= load_byte & (ptr_reg == `OFS_FLAGS_B);
      int_b_reg <= ~pending;
    end
  end

  assign O_SDA_OUT                = sda_out_reg;
  assign O_SDA_OE                 = sda_oe_reg;
  assign O_APPLY_VOLTAGE_SETPOINT = apply_reg;
  assign O_MAIN_ENABLE            = enable_reg;
  assign O_INT_B                  = int_b_reg;

endmodule

// file: charger_regs.vh
//==========================================================================
// Behaviour
// - flag a bit 7 sets on every change between current and voltage regulation.
// - flag a bit 5 sets when the external sync clock is out of range.
// - flag a bit 4 sets when the frequency resistor probe is out of range.
// - flag a bit 3 sets on hard thermal trip, bit 2 on soft trip.
// - flag a bit 0 sets on input over-voltage lockout.
// - flag b bit 6 sets while main output over-current persists.
// - flag b bit 5 sets on main output over-voltage.
// - flag b bit 4 sets on main output under-voltage, either regulation mode.
// - flag b bit 3 sets on auxiliary regulator under-voltage.
// - flag b bits 2, 1, 0: bias converter over-current, over-voltage, under-voltage.
// - status bits 7 and 6 show sync clock too fast and too slow.
// - status bit 5 shows bias converter at full duty; raises no interrupt.
// - status bit 4 is 1 in current regulation, 0 in voltage regulation.
// - status bit 3 shows main converter at full duty.
// - status bit 2 shows main output good.
// - writing 1 to command bit 1 applies the setpoint; bit reads 0.
// - writing 1 to command bit 0 enables the main converter.
// - a 1 in a mask byte blocks the same flag bit from interrupting.
// - mask-all set makes every mask bit act as 1.
// - reading a flag byte clears its set bits.
// - a flag whose cause is still present survives the read.
// - mask-all is config byte 1 bit 5 and resets to 1.
//==========================================================================
`ifndef CHARGER_REGS_VH
`define CHARGER_REGS_VH

// register offsets
`define OFS_STATE        8'h00
`define OFS_FLAGS_A      8'h01
`define OFS_FLAGS_B      8'h02
`define OFS_LIVE         8'h03
`define OFS_SPARE        8'h04
`define OFS_ACTION       8'h05
`define OFS_GATE_A       8'h06
`define OFS_GATE_B       8'h07
`define OFS_CFG1         8'h08

// event_flags_a bit positions
`define FA_MODE_CHANGE   7
`define FA_EXT_CLOCK     5
`define FA_FREQ_RES      4
`define FA_HARD_TRIP     3
`define FA_SOFT_TRIP     2
`define FA_INPUT_OVLO    0

// event_flags_b bit positions
`define FB_MAIN_OC       6
`define FB_MAIN_OV       5
`define FB_MAIN_UV       4
`define FB_AUX_UV        3
`define FB_BIAS_OC       2
`define FB_BIAS_OV       1
`define FB_BIAS_UV       0

// live_condition_flags bit positions
`define ST_TOO_FAST      7
`define ST_TOO_SLOW      6
`define ST_BIAS_FULL     5
`define ST_CURRENT_REG   4
`define ST_MAIN_FULL     3
`define ST_MAIN_GOOD     2

// action_trigger and config byte 1 bit positions
`define ACT_APPLY        1
`define ACT_ENABLE       0
`define CFG1_MASK_ALL    5

// reset values
`define RST_ACTION       8'h00
`define RST_GATE         8'h00
`define RST_CFG1         8'h28

// bits that exist in each byte
`define USED_FLAGS_A     8'hBD
`define USED_FLAGS_B     8'h7F
`define USED_CFG1        8'hF8

// default serial slave address
`define DEV_ADDR_DEFAULT 7'h25

`endif

// file: in_sync.v
`timescale 1ns/100ps
//==========================================================================
// three-stage synchroniser with agreement filter
//==========================================================================
module in_sync #(
  parameter W    = 1,
  parameter INIT = 1'b0
) (
  input  wire         i_clk,
  input  wire         i_rst_b,
  input  wire [W-1:0] i_async,
  output wire [W-1:0] o_level
);

  reg [W-1:0] s1_reg;
  reg [W-1:0] s2_reg;
  reg [W-1:0] s3_reg;
  reg [W-1:0] level_reg;
  wire [W-1:0] agree;

  // a bit only moves once stages two and three agree
  assign agree   = ~(s2_reg ^ s3_reg);
  assign o_level = level_reg;

  // sampling chain; first stage feeds only the second
  always @(posedge i_clk) begin
    if (!i_rst_b) begin
      s1_reg    <= {W{INIT}};
      s2_reg    <= {W{INIT}};
      s3_reg    <= {W{INIT}};
      level_reg <= {W{INIT}};
    end else begin
      s1_reg    <= i_async;
      s2_reg    <= s1_reg;
      s3_reg    <= s2_reg;
      level_reg <= (s2_reg & agree) | (level_reg & ~agree);
    end
  end

endmodule

// file: event_latch_bank.v
`timescale 1ns/100ps
//==========================================================================
// byte of sticky event flags, cleared on read
//==========================================================================
module event_latch_bank #(
  parameter [7:0] USED = 8'hFF
) (
  input  wire       i_clk,
  input  wire       i_rst_b,
  input  wire [7:0] i_cause,
  input  wire       i_read_clr,
  output wire [7:0] o_flags
);

  genvar g;

  generate
    for (g = 0; g < 8; g = g + 1) begin : bit_cell
      if (USED[g]) begin : live
        reg flag_reg;
        wire flag_next;
        // a present cause wins over the read clear
        assign flag_next = i_cause[g] | (flag_reg & ~i_read_clr);
        always @(posedge i_clk) begin
          if (!i_rst_b) begin
            flag_reg <= 1'b0;
          end else begin
            flag_reg <= flag_next;
          end
        end
        assign o_flags[g] = flag_reg;
      end else begin : unused
        assign o_flags[g] = 1'b0;
      end
    end
  endgenerate

endmodule

// file: charger_event_status_regs_assertions.sv
`timescale 1ns/100ps
//==========================================
// link, action pulse and interrupt checks
//==========================================
module charger_event_status_regs_chk (
  input wire I_CLK,
  input wire I_RST_B,
  input wire I_SCL,
  input wire O_SDA_OE,
  input wire O_APPLY_VOLTAGE_SETPOINT,
  input wire O_MAIN_ENABLE,
  input wire O_INT_B
);
  reg [5:0] link_age;
  reg       scl_q;
  reg       seen;

  default clocking @(posedge I_CLK); endclocking
  default disable iff (!I_RST_B);

  // cycles since the serial clock pin last moved, saturating
  always @(posedge I_CLK) begin
    scl_q <= I_SCL;
    if (!I_RST_B) begin
      link_age <= 6'h3F;
      seen     <= 1'b0;
    end else begin
      seen     <= seen | (I_SCL != scl_q);
      link_age <= (I_SCL != scl_q) ? 6'h00 : link_age + {5'h00, link_age != 6'h3F};
    end
  end

  enable_pulse_a: assert property (O_MAIN_ENABLE |=> !O_MAIN_ENABLE)
    else $error("enable pulse longer than one cycle");
  apply_pulse_a: assert property (O_APPLY_VOLTAGE_SETPOINT |=> !O_APPLY_VOLTAGE_SETPOINT)
    else $error("apply pulse longer than one cycle");
  action_link_a: assert property ((O_MAIN_ENABLE || O_APPLY_VOLTAGE_SETPOINT) |-> link_age < 6'h08)
    else $error("action pulse without a host write");
  ack_phase_a: assert property ($changed(O_SDA_OE) |-> !I_SCL)
    else $error("data line moved while serial clock high");
  oe_timing_a: assert property ($changed(O_SDA_OE) |-> link_age < 6'h06)
    else $error("data line moved long after a clock edge");
  masked_start_a: assert property (!seen |-> O_INT_B)
    else $error("interrupt before any host access");
  reset_int_a: assert property ($rose(I_RST_B) |-> O_INT_B && !O_SDA_OE)
    else $error("outputs not idle after reset");
  int_release_a: assert property ($rose(O_INT_B) |-> link_age < 6'h10)
    else $error("interrupt released without a host access");

  cover property (O_MAIN_ENABLE && O_APPLY_VOLTAGE_SETPOINT);
  cover property ($fell(O_INT_B));
  cover property ($rose(O_INT_B));
endmodule

// file: serial_host_model.sv
`timescale 1ns/100ps
//==========================================
// serial link host: open-drain data, clock idles high
//==========================================
module serial_host_model #(
  parameter [6:0] DEV = 7'h25
) (
  input  wire i_clk,
  input  wire i_sda,
  output reg  o_scl,
  output reg  o_sda_low
);
  initial begin
    o_scl = 1'b1;
    o_sda_low = 1'b0;
  end

  // every pin change lands at a falling edge of the system clock
  task tick(input integer n);
    repeat (n) @(negedge i_clk);
  endtask

  // one bit: 6 cycles low, 5 high, data sampled mid high phase
  task bitx(input b, output r);
    begin
      tick(3);
      o_sda_low = !b;
      tick(3);
      o_scl = 1'b1;
      tick(3);
      r = i_sda;
      tick(2);
      o_scl = 1'b0;
    end
  endtask

  // eight bits msb first plus the acknowledge slot
  task xfer(input [8:0] o, output [8:0] i);
    integer k;
    for (k = 8; k >= 0; k = k - 1) bitx(o[k], i[k]);
  endtask

  task start;
    begin
      tick(3);
      o_sda_low = 1'b0;
      tick(3);
      o_scl = 1'b1;
      tick(3);
      o_sda_low = 1'b1;
      tick(3);
      o_scl = 1'b0;
    end
  endtask

  task stop;
    begin
      tick(3);
      o_sda_low = 1'b1;
      tick(3);
      o_scl = 1'b1;
      tick(3);
      o_sda_low = 1'b0;
      tick(3);
    end
  endtask

  // register write; ok high when all three bytes were acknowledged
  task wr(input [7:0] a, input [7:0] d, output ok);
    reg [8:0] r1, r2, r3;
    begin
      start;
      xfer({DEV, 2'b01}, r1);
      xfer({a, 1'b1}, r2);
      xfer({d, 1'b1}, r3);
      stop;
      ok = !(r1[0] | r2[0] | r3[0]);
    end
  endtask

  // single byte read with repeated start, ended by a host nack
  task rd(input [7:0] a, output [7:0] d, output ok);
    reg [8:0] r1, r2, r3, r4;
    begin
      start;
      xfer({DEV, 2'b01}, r1);
      xfer({a, 1'b1}, r2);
      start;
      xfer({DEV, 2'b11}, r3);
      xfer(9'h1FF, r4);
      stop;
      d = r4[8:1];
      ok = !(r1[0] | r2[0] | r3[0]);
    end
  endtask
endmodule

// file: tb_top.sv
`timescale 1ns/100ps
//==========================================
// bench top
//==========================================
module tb_top;
  reg        i_clk;
  reg        i_rst_b;
  reg [15:0] cause;
  reg [7:2]  live;
  reg [7:0]  rdat;
  reg        ok;
  integer    num_errors, samples_checked, k, en_cnt, ap_cnt;
  wire       scl, sda_low, sda_oe, sda_out, apply, enable, int_b;
  // pulled-up data wire
  wire       sda = !(sda_low | (sda_oe & !sda_out));

  charger_event_status_regs u_charger_event_status_regs (
    .I_CLK(i_clk), .I_RST_B(i_rst_b), .I_SCL(scl), .I_SDA(sda), .O_SDA_OUT(sda_out),
    .O_SDA_OE(sda_oe), .I_MAIN_CURRENT_REGULATING(live[4]),
    .I_EXT_CLOCK_RANGE_FAULT(cause[13]), .I_FREQ_RESISTOR_RANGE_FAULT(cause[12]),
    .I_HARD_THERMAL_TRIP(cause[11]), .I_SOFT_THERMAL_TRIP(cause[10]),
    .I_INPUT_OVERVOLTAGE_LOCKOUT(cause[8]), .I_MAIN_OVERCURRENT(cause[6]),
    .I_MAIN_OVERVOLTAGE_FLAG(cause[5]), .I_MAIN_UNDERVOLTAGE_FLAG(cause[4]),
    .I_AUX_REGULATOR_UNDERVOLTAGE(cause[3]), .I_BIAS_CONV_OVERCURRENT(cause[2]),
    .I_BIAS_CONV_OVERVOLTAGE(cause[1]), .I_BIAS_CONV_UNDERVOLTAGE(cause[0]),
    .I_EXT_CLOCK_TOO_FAST(live[7]), .I_EXT_CLOCK_TOO_SLOW(live[6]),
    .I_BIAS_FULL_DUTY(live[5]), .I_MAIN_FULL_DUTY(live[3]), .I_MAIN_OUTPUT_GOOD(live[2]),
    .O_APPLY_VOLTAGE_SETPOINT(apply), .O_MAIN_ENABLE(enable), .O_INT_B(int_b)
  );

  serial_host_model u_serial_host_model (
    .i_clk(i_clk), .i_sda(sda), .o_scl(scl), .o_sda_low(sda_low)
  );

  initial begin
    i_clk = 1'b0;
    forever #12.5 i_clk = ~i_clk;
  end

  // action pulse counters
  always @(posedge i_clk) begin
    en_cnt <= en_cnt + enable;
    ap_cnt <= ap_cnt + apply;
  end

  task check(input [8*6-1:0] name, input [7:0] seen, input [7:0] exp);
    begin
      samples_checked = samples_checked + 1;
      if (seen !== exp) begin
        num_errors = num_errors + 1;
        $display("MISMATCH %s exp %h seen %h", name, exp, seen);
      end
    end
  endtask

  task rchk(input [7:0] a, input [7:0] e);
    begin
      u_serial_host_model.rd(a, rdat, ok);
      check("ack", {7'h00, ok}, 8'h01);
      check("regval", rdat, e);
    end
  endtask

  task wchk(input [7:0] a, input [7:0] d);
    begin
      u_serial_host_model.wr(a, d, ok);
      check("ack", {7'h00, ok}, 8'h01);
    end
  endtask

  task end_sim;
    begin
      $display("checked %0d errors %0d", samples_checked, num_errors);
      if (num_errors == 0 && samples_checked > 0)
        $display("== PASSED ==");
      else
        $display("== FAILED ==");
      $finish;
    end
  endtask

  // run limit
  initial begin
    repeat (90000) @(posedge i_clk);
    num_errors = num_errors + 1;
    end_sim;
  end

  initial begin
    i_rst_b = 1'b0;
    cause = 16'h0000;
    live = 6'h00;
    num_errors = 0;
    samples_checked = 0;
    en_cnt = 0;
    ap_cnt = 0;
    u_serial_host_model.tick(6);
    i_rst_b = 1'b1;
    // cause before any access stays masked
    cause[11] = 1'b1;
    u_serial_host_model.tick(10);
    cause = 16'h0000;
    u_serial_host_model.tick(8);
    check("int_b", {7'h00, int_b}, 8'h01);
    rchk(8'h05, 8'h00);
    rchk(8'h06, 8'h00);
    rchk(8'h07, 8'h00);
    rchk(8'h08, 8'h28);
    rchk(8'h04, 8'h00);
    rchk(8'h20, 8'h00);
    rchk(8'h01, 8'h08);
    rchk(8'h01, 8'h00);
    rchk(8'h02, 8'h00);
    $display("test reset done");
    // each cause sets its own bit, the read clears it
    for (k = 0; k < 16; k = k + 1) begin
      if (k != 7 && k != 9 && k < 14) begin
        cause = 16'h0001 << k;
        u_serial_host_model.tick(10);
        cause = 16'h0000;
        u_serial_host_model.tick(8);
        rchk((k > 7) ? 8'h01 : 8'h02, 8'h01 << (k % 8));
        rchk((k > 7) ? 8'h01 : 8'h02, 8'h00);
      end
    end
    // flag survives reads while its cause stands
    cause[8] = 1'b1;
    u_serial_host_model.tick(10);
    rchk(8'h01, 8'h01);
    rchk(8'h01, 8'h01);
    cause = 16'h0000;
    u_serial_host_model.tick(8);
    rchk(8'h01, 8'h01);
    rchk(8'h01, 8'h00);
    $display("test flags done");
    // masking
    cause[10] = 1'b1;
    u_serial_host_model.tick(10);
    cause = 16'h0000;
    u_serial_host_model.tick(8);
    check("int_b", {7'h00, int_b}, 8'h01);
    wchk(8'h08, 8'h08);
    check("int_b", {7'h00, int_b}, 8'h00);
    wchk(8'h06, 8'h04);
    check("int_b", {7'h00, int_b}, 8'h01);
    wchk(8'h06, 8'h00);
    check("int_b", {7'h00, int_b}, 8'h00);
    rchk(8'h01, 8'h04);
    check("int_b", {7'h00, int_b}, 8'h01);
    $display("test mask done");
    // live conditions, walking one from the top bit
    for (k = 7; k >= 2; k = k - 1) begin
      live = 6'h01 << (k - 2);
      u_serial_host_model.tick(8);
      rchk(8'h03, 8'h01 << k);
      if (k > 4)
        check("int_b", {7'h00, int_b}, 8'h01);
    end
    live = 6'h00;
    u_serial_host_model.tick(8);
    check("int_b", {7'h00, int_b}, 8'h00);
    rchk(8'h01, 8'h80);
    $display("test status done");
    // command pulses and readback
    wchk(8'h05, 8'h03);
    check("enable", en_cnt[7:0], 8'h01);
    check("apply", ap_cnt[7:0], 8'h01);
    rchk(8'h05, 8'h01);
    $display("test command done");
    end_sim;
  end
endmodule

bind charger_event_status_regs charger_event_status_regs_chk u_chk (.*);
